/* File: hw/arc_pkg.sv */
// Purpose: constants for the converter reference and ground select control
// Assumes: byte-wide special-function register port, page-qualified addresses
// Notes:   offsets are the printed addresses
package arc_pkg;
  localparam logic [3:0] PAGE_REF        = 4'h0;
  localparam logic [3:0] PAGE_OFFSET     = 4'hf;
  localparam logic [7:0] ADDR_REF_CTRL   = 8'hd1;
  localparam logic [7:0] ADDR_FACTORY_TEMP_OFFSET_LOW   = 8'h85;
  localparam int         GND_SEL_BIT     = 5;
  localparam int         REF_SEL_HI      = 4;
  localparam int         REF_SEL_LO      = 3;
  localparam int         TEMP_EN_BIT     = 2;
  localparam int         PREC_OE_BIT     = 0;
  localparam int         FACTORY_TEMP_OFFSET_LOW_HI     = 7;
  localparam int         FACTORY_TEMP_OFFSET_LOW_LO     = 6;
  localparam int         FACTORY_TEMP_OFFSET_WIDTH      = 10;
  localparam logic [7:0] REF_CTRL_WMASK  = 8'h3d;
  localparam logic [7:0] REF_CTRL_RESET  = 8'h18;
  localparam logic [1:0] SEL_EXTERNAL    = 2'h0;
  localparam logic [1:0] SEL_SUPPLY      = 2'h1;
  localparam logic [1:0] SEL_DIGITAL     = 2'h2;
  localparam logic [1:0] SEL_HIGH_SPEED  = 2'h3;
  localparam logic [4:0] CHAN_TEMP       = 5'h1b;
endpackage : arc_pkg

/* File: hw/arc_ref_ctrl.sv */
// Purpose: reference and ground selection for the converter
// Assumes: sequencer phase inputs are on clk; register port is synchronous
// Notes:   analog switch controls are registered one-hot-ish enables
module arc_ref_ctrl #(
  parameter logic [9:0] FACTORY_OFFSET = 10'h000 // trimmed per part; value arbitrary
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] sfr_page,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       track_active,
  input  wire logic       conv_active,
  input  wire logic [4:0] mux_channel,
  output logic            sel_ext_pin,
  output logic            sel_supply,
  output logic            sel_digital,
  output logic            sel_high_speed,
  output logic            high_speed_power,
  output logic            precision_ref_power,
  output logic            precision_ref_drive_pin,
  output logic            gnd_from_pin,
  output logic            temp_sensor_power
);

  initial begin
    if ($bits(FACTORY_OFFSET) != arc_pkg::FACTORY_TEMP_OFFSET_WIDTH) begin
      $error("offset width mismatch");
    end
  end

  // register state
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // one flop per analog control, so every switch input comes straight from a flop
  logic       ext_pin_ff;
  logic       nxt_ext_pin;
  logic       supply_ff;
  logic       nxt_supply;
  logic       digital_ff;
  logic       nxt_digital;
  logic       high_speed_ff;
  logic       nxt_high_speed;
  logic       hs_power_ff;
  logic       nxt_hs_power;
  logic       prec_power_ff;
  logic       nxt_prec_power;
  logic       prec_drive_ff;
  logic       nxt_prec_drive;
  logic       gnd_pin_ff;
  logic       nxt_gnd_pin;
  logic       sensor_power_ff;
  logic       nxt_sensor_power;

  // decode of the port and of the control fields
  logic       hit_ctrl;
  logic       hit_factory_temp_offset;
  logic [1:0] ref_sel;
  logic       prec_oe;
  logic       gnd_sel;
  logic       sensor_en;
  logic       busy;
  logic       temp_tracking;
  logic       hs_converting;

  assign hit_ctrl      = (sfr_page == arc_pkg::PAGE_REF)
                      && (sfr_addr == arc_pkg::ADDR_REF_CTRL);
  assign hit_factory_temp_offset      = (sfr_page == arc_pkg::PAGE_OFFSET)
                      && (sfr_addr == arc_pkg::ADDR_FACTORY_TEMP_OFFSET_LOW);
  assign ref_sel       = ctrl_ff[arc_pkg::REF_SEL_HI:arc_pkg::REF_SEL_LO];
  assign prec_oe       = ctrl_ff[arc_pkg::PREC_OE_BIT];
  assign gnd_sel       = ctrl_ff[arc_pkg::GND_SEL_BIT];
  assign sensor_en     = ctrl_ff[arc_pkg::TEMP_EN_BIT];
  assign busy          = track_active || conv_active;
  assign temp_tracking = track_active && (mux_channel == arc_pkg::CHAN_TEMP);
  assign hs_converting = conv_active && (ref_sel == arc_pkg::SEL_HIGH_SPEED);

  // register port: only the writable bits store; unused bits stay zero
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = rdata_ff;
    if (sfr_wr && hit_ctrl) begin
      nxt_ctrl = sfr_wdata & arc_pkg::REF_CTRL_WMASK;
    end
    if (sfr_rd) begin
      if (hit_ctrl) begin
        nxt_rdata = ctrl_ff;
      end else if (hit_factory_temp_offset) begin
        nxt_rdata = {FACTORY_OFFSET[1:0], 6'h00};
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff  <= arc_pkg::REF_CTRL_RESET;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  // analog controls; all registered so switches never see decode glitches
  always_comb begin
    // the pin feeds the converter with select 00; a driven precision ref also sits there
    nxt_ext_pin      = ((ref_sel == arc_pkg::SEL_EXTERNAL) && !prec_oe) || prec_oe;
    nxt_supply       = (ref_sel == arc_pkg::SEL_SUPPLY);
    nxt_digital      = (ref_sel == arc_pkg::SEL_DIGITAL);
    nxt_high_speed   = (ref_sel == arc_pkg::SEL_HIGH_SPEED);
    // low-power between conversions keeps idle current down
    nxt_hs_power     = (ref_sel == arc_pkg::SEL_HIGH_SPEED) && busy;
    // the output enable powers it whatever the select holds
    nxt_prec_power   = prec_oe;
    nxt_prec_drive   = prec_oe;
    // ground pin used in both phases unless an internal-ground case applies
    nxt_gnd_pin      = gnd_sel && busy
                    && !temp_tracking
                    && !hs_converting;
    nxt_sensor_power = sensor_en;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_pin_ff      <= 1'b0;
      supply_ff       <= 1'b0;
      digital_ff      <= 1'b0;
      high_speed_ff   <= 1'b1;
      hs_power_ff     <= 1'b0;
      prec_power_ff   <= 1'b0;
      prec_drive_ff   <= 1'b0;
      gnd_pin_ff      <= 1'b0;
      sensor_power_ff <= 1'b0;
    end else begin
      ext_pin_ff      <= nxt_ext_pin;
      supply_ff       <= nxt_supply;
      digital_ff      <= nxt_digital;
      high_speed_ff   <= nxt_high_speed;
      hs_power_ff     <= nxt_hs_power;
      prec_power_ff   <= nxt_prec_power;
      prec_drive_ff   <= nxt_prec_drive;
      gnd_pin_ff      <= nxt_gnd_pin;
      sensor_power_ff <= nxt_sensor_power;
    end
  end

  assign sfr_rdata               = rdata_ff;
  assign sel_ext_pin             = ext_pin_ff;
  assign sel_supply              = supply_ff;
  assign sel_digital             = digital_ff;
  assign sel_high_speed          = high_speed_ff;
  assign high_speed_power        = hs_power_ff;
  assign precision_ref_power     = prec_power_ff;
  assign precision_ref_drive_pin = prec_drive_ff;
  assign gnd_from_pin            = gnd_pin_ff;
  assign temp_sensor_power       = sensor_power_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  factory_temp_offset_read_a: assert property (
    sfr_rd && hit_factory_temp_offset
    |=> sfr_rdata == {FACTORY_OFFSET[1:0], 6'h00}
  ) else $error("offset low read wrong");

  factory_temp_offset_zero_a: assert property (
    sfr_rd && hit_factory_temp_offset
    |=> sfr_rdata[5:0] == 6'h00
  ) else $error("offset low bits not zero");

  factory_temp_offset_wr_a: assert property (
    sfr_wr && hit_factory_temp_offset
    |=> $stable(ctrl_ff)
  ) else $error("offset write changed state");

  hs_route_a: assert property (
    ref_sel == arc_pkg::SEL_HIGH_SPEED
    |=> sel_high_speed
  ) else $error("high-speed reference not routed");

  hs_off_a: assert property (
    ref_sel != arc_pkg::SEL_HIGH_SPEED
    |=> !sel_high_speed && !high_speed_power
  ) else $error("high-speed reference used unselected");

  hs_idle_a: assert property (
    !busy
    |=> !high_speed_power
  ) else $error("high-speed reference powered while idle");

  hs_busy_a: assert property (
    busy && ref_sel == arc_pkg::SEL_HIGH_SPEED
    |=> high_speed_power
  ) else $error("high-speed reference not powered");

  prec_on_a: assert property (
    prec_oe
    |=> precision_ref_power && precision_ref_drive_pin && sel_ext_pin
  ) else $error("precision ref off");

  prec_off_a: assert property (
    !prec_oe
    |=> !precision_ref_power && !precision_ref_drive_pin
  ) else $error("precision ref on without enable");

  ext_sel_a: assert property (
    ref_sel == arc_pkg::SEL_EXTERNAL
    |=> sel_ext_pin && !sel_supply && !sel_digital
  ) else $error("reference pin not selected");

  supply_sel_a: assert property (
    ref_sel == arc_pkg::SEL_DIGITAL
    |=> sel_digital && !sel_supply
  ) else $error("digital supply not selected");

  main_sel_a: assert property (
    ref_sel == arc_pkg::SEL_SUPPLY
    |=> sel_supply && !sel_digital
  ) else $error("main supply not selected");

  gnd_pin_a: assert property (
    gnd_sel && track_active && mux_channel != arc_pkg::CHAN_TEMP
    |=> gnd_from_pin
  ) else $error("ground pin dropped");

  gnd_conv_a: assert property (
    gnd_sel && conv_active && ref_sel != arc_pkg::SEL_HIGH_SPEED
    |=> gnd_from_pin
  ) else $error("ground pin dropped in conversion");

  temp_gnd_a: assert property (
    track_active && mux_channel == arc_pkg::CHAN_TEMP
    |=> !gnd_from_pin
  ) else $error("sensor sampled on pin ground");

  hs_gnd_a: assert property (
    conv_active && ref_sel == arc_pkg::SEL_HIGH_SPEED
    |=> !gnd_from_pin
  ) else $error("pin ground during high-speed conversion");

  gnd_off_a: assert property (
    !gnd_sel
    |=> !gnd_from_pin
  ) else $error("pin ground without select");

  sensor_en_a: assert property (
    temp_sensor_power == $past(sensor_en)
  ) else $error("sensor power wrong");

  ctrl_wr_a: assert property (
    sfr_wr && hit_ctrl
    |=> ctrl_ff == ($past(sfr_wdata) & arc_pkg::REF_CTRL_WMASK)
  ) else $error("ctrl write lost");

  ctrl_rd_a: assert property (
    sfr_rd && hit_ctrl
    |=> sfr_rdata == $past(ctrl_ff)
  ) else $error("ctrl read wrong");

  ctrl_rsvd_a: assert property (
    (ctrl_ff & ~arc_pkg::REF_CTRL_WMASK) == 8'h00
  ) else $error("ctrl unused bits set");

  // main scenarios reached by the bench
  hs_conv_c: cover property (ref_sel == arc_pkg::SEL_HIGH_SPEED && conv_active);
  gnd_track_c: cover property (gnd_from_pin ##1 !gnd_from_pin);
  temp_sample_c: cover property (track_active && mux_channel == arc_pkg::CHAN_TEMP);
  prec_c: cover property (precision_ref_power);
  prec_ext_c: cover property (prec_oe && ref_sel == arc_pkg::SEL_EXTERNAL && busy);

endmodule : arc_ref_ctrl

/* File: testbench/arc_seq_model.sv */
// Purpose: converter sequencer stand-in driving tracking then conversion
// Assumes: both phase lengths are one cycle or more
// Notes:   drives on the falling edge so the design samples settled levels
module arc_seq_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic [4:0] chan,
  input  wire logic [3:0] trk_len,
  input  wire logic [3:0] cnv_len,
  output logic            track_active = 1'b0,
  output logic            conv_active = 1'b0,
  output logic      [4:0] mux_channel = 5'h0,
  output logic            busy
);
  logic [4:0] ph = 5'h0;
  logic [4:0] n;
  assign n = ph + 5'h1;
  assign busy = (ph != 5'h0);
  always @(negedge clk) begin
    if (sys_rst || (busy && n > trk_len + cnv_len)) begin
      ph <= 5'h0;
      track_active <= 1'b0;
      conv_active <= 1'b0;
    end else if (busy || start) begin
      ph <= n;
      track_active <= (n <= {1'b0, trk_len});
      conv_active <= (n > {1'b0, trk_len});
      if (!busy) mux_channel <= chan; // channel only moves between conversions
    end
  end
endmodule : arc_seq_model

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the converter reference control
// Assumes: one-cycle register strobes; sequencer stand-in drives the phases
// Notes:   outputs checked every settled cycle, skipped while a write lands
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] OFFS = 10'h2c3; // arbitrary trim value
  logic clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, arm = 1'b0;
  logic p_trk, p_cnv, trk, cnv, bsy;
  logic [3:0] page = 4'h0, tl = 4'h1, cl = 4'h1;
  logic [4:0] ch = 5'h0, p_ch, mch;
  logic [7:0] addr = 8'h0, wd = 8'h0, rdat, ctl = 8'h18, c1, c2;
  logic [8:0] got;
  logic [31:0] seed = 32'he1e2e06a;
  int error_cnt = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  arc_ref_ctrl #(.FACTORY_OFFSET(OFFS)) u_arc_ref_ctrl (.clk(clk), .sys_rst(sys_rst),
    .sfr_page(page), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd),
    .sfr_rdata(rdat), .track_active(trk), .conv_active(cnv), .mux_channel(mch),
    .sel_ext_pin(got[8]), .sel_supply(got[7]), .sel_digital(got[6]),
    .sel_high_speed(got[5]), .high_speed_power(got[4]), .precision_ref_power(got[3]),
    .precision_ref_drive_pin(got[2]), .gnd_from_pin(got[1]), .temp_sensor_power(got[0]));
  arc_seq_model u_arc_seq_model (.clk(clk), .sys_rst(sys_rst), .start(go), .chan(ch),
    .trk_len(tl), .cnv_len(cl), .track_active(trk), .conv_active(cnv),
    .mux_channel(mch), .busy(bsy));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // idle ground is internal; temperature tracking and fast-reference conversion override
  function automatic logic [8:0] exp_out(logic [7:0] c, logic t, logic v, logic [4:0] m);
    logic [1:0] s;
    s = c[4:3];
    return {s == 2'h0 || c[0], s == 2'h1, s == 2'h2, s == 2'h3, s == 2'h3 && (t || v), c[0],
      c[0], c[5] && (t || v) && !(t && m == arc_pkg::CHAN_TEMP) && !(v && s == 2'h3), c[2]};
  endfunction : exp_out
  task automatic chk(logic [8:0] g, logic [8:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(logic w, logic [3:0] pg, logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    {wr, rd, page, addr, wd} = {w, !w, pg, a, d};
    if (w && pg == arc_pkg::PAGE_REF && a == arc_pkg::ADDR_REF_CTRL) ctl = d & 8'h3d;
    @(negedge clk);
    {wr, rd} = 2'b00;
    @(negedge clk);
  endtask : acc
  task automatic rchk(logic [3:0] pg, logic [7:0] a, logic [7:0] e);
    acc(1'b0, pg, a, 8'h00);
    chk({1'b0, rdat}, {1'b0, e});
  endtask : rchk
  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    {c1, c2, arm} <= {ctl, c1, !sys_rst};
    {p_trk, p_cnv, p_ch} <= {trk, cnv, mch};
  end
  always @(negedge clk) begin
    if (arm && c1 == ctl && c2 == ctl) begin
      chk(got, exp_out(ctl, p_trk, p_cnv, p_ch));
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    rchk(4'h0, 8'hd1, 8'h18);
    acc(1'b1, 4'hf, 8'h85, 8'hff);
    rchk(4'hf, 8'h85, {OFFS[1:0], 6'h00});
    acc(1'b1, 4'h1, 8'hd1, 8'h00);
    rchk(4'h1, 8'hd1, 8'h00);
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      // bench clock stands for no precision oscillator, so enabling the ref is safe
      acc(1'b1, 4'h0, 8'hd1, {seed[7:5], i[1:0], seed[2:0]});
      rchk(4'h0, 8'hd1, ctl);
      tl = {1'b0, seed[10:8]} + 4'h1;
      cl = {1'b0, seed[14:12]} + 4'h1;
      ch = (seed[17:16] == 2'h0) ? arc_pkg::CHAN_TEMP : seed[22:18];
      @(negedge clk) go <= 1'b1;
      @(negedge clk) go <= 1'b0;
      @(negedge clk);
      while (bsy) @(negedge clk);
    end
    @(negedge clk);
    {sys_rst, ctl} = {1'b1, 8'h18};
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rchk(4'h0, 8'hd1, 8'h18);
    close_out();
  end
endmodule : tb
